/* File: core/iopd_pkg.sv */
// package for the i/o port decode and acknowledge block
// assumes an 8-bit port address and a 100 MHz core clock
package iopd_pkg;
  // ----------------------------------------------------------------
  // port addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_CNT_BASE  = 8'h00_F0; // counter chip base, f0..f3
  localparam logic [7:0] PORT_SER_BASE  = 8'h00_F4; // serial channels, f4..f7
  localparam logic [7:0] PORT_PAR_BASE  = 8'h00_F8; // parallel subsystem, f8/f9
  localparam logic [7:0] PORT_LINT_BASE = 8'h00_FA; // local interrupt ctrl, fa/fb
  localparam logic [7:0] PORT_SINT_BASE = 8'h00_FC; // system interrupt ctrl, fc/fd
  localparam logic [7:0] PORT_RSVD_FE   = 8'h00_FE; // reserved, selects nothing
  localparam logic [7:0] PORT_ROM_LATCH = 8'h00_FF; // rom segment enable latch
  localparam logic [7:0] PORT_IOC_BASE  = 8'h00_C0; // i/o controller, c0..c3
  localparam logic [7:0] PORT_RSVD_C4   = 8'h00_C4; // reserved external, c4/c5
  // masks that drop low address bits from a port group compare
  localparam logic [7:0] MASK_PAIR      = 8'h00_FE;
  localparam logic [7:0] MASK_QUAD      = 8'h00_FC;
  localparam logic [7:0] MASK_OCT       = 8'h00_F8;
  // group of counter plus serial ports, f0..f7
  localparam logic [7:0] PORT_GRP_BASE  = 8'h00_F0;
  // ----------------------------------------------------------------
  // register reset value and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] ROM_LATCH_RST  = 8'h00_00; // latch reset value
  localparam int         ACK_TIME_NS    = 1600;     // 1.6 us acknowledge time
  localparam int         CLK_PERIOD_NS  = 10;       // 100 MHz core clock
  localparam int         ACK_CYCLES_I   = (ACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] ACK_CYCLES     = ACK_CYCLES_I[7:0]; // 160 cycles
  localparam logic [7:0] ACK_ONE        = 8'h00_01;
  // ----------------------------------------------------------------
  // acknowledge timer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ACK_IDLE = 3'b001, // no local cycle
    ACK_RUN  = 3'b010, // counting toward ready
    ACK_DONE = 3'b100  // ready held until command ends
  } iopd_ack_state_t;
endpackage

/* File: core/iopd_sel_if.sv */
// decoded selects passed from the decoder to the top module
// assumes active low selects as produced by the decoder
`timescale 1ns/100ps
`default_nettype none
interface iopd_sel_if;
  logic cnt_grp_n;          // counter/serial group, f0..f7
  logic lint_n;             // local interrupt controller
  logic sint_n;             // system interrupt controller
  logic par_n;              // parallel subsystem
  logic ioc_n;              // i/o controller
  logic rom_n;              // rom latch
  logic ext_n;              // external driver enable
  logic int_en_n;           // local transceiver enable
  logic local_n;            // common local select
  modport dec (output cnt_grp_n, lint_n, sint_n, par_n, ioc_n, rom_n, ext_n, int_en_n, local_n);
  modport top (input  cnt_grp_n, lint_n, sint_n, par_n, ioc_n, rom_n, ext_n, int_en_n, local_n);
endinterface
`default_nettype wire

/* File: core/iopd_port_decoder.sv */
// combinational port address decoder
// assumes address stable for the whole command
`timescale 1ns/100ps
`default_nettype none
module iopd_port_decoder (
  input  wire logic [7:0] port_addr,
  iopd_sel_if.dec         sel
);
  // ----------------------------------------------------------------
  // address compare, address only, no command
  // ----------------------------------------------------------------
  always_comb
  begin
    sel.cnt_grp_n = !((port_addr & iopd_pkg::MASK_OCT) == iopd_pkg::PORT_GRP_BASE);
    sel.lint_n    = !((port_addr & iopd_pkg::MASK_PAIR) == iopd_pkg::PORT_LINT_BASE);
    sel.sint_n    = !((port_addr & iopd_pkg::MASK_PAIR) == iopd_pkg::PORT_SINT_BASE);
    sel.par_n     = !((port_addr & iopd_pkg::MASK_PAIR) == iopd_pkg::PORT_PAR_BASE);
    sel.ioc_n     = !((port_addr & iopd_pkg::MASK_QUAD) == iopd_pkg::PORT_IOC_BASE);
    sel.rom_n     = !(port_addr == iopd_pkg::PORT_ROM_LATCH);
    // external drivers also cover reserved c4/c5
    sel.ext_n     = sel.par_n && sel.ioc_n
                    && !((port_addr & iopd_pkg::MASK_PAIR) == iopd_pkg::PORT_RSVD_C4);
    // transceiver serves the counter/serial group and the local controller, not the system controller or rom latch
    sel.int_en_n  = sel.cnt_grp_n && sel.lint_n;
    // fe is the only f-range port outside local select
    sel.local_n   = sel.cnt_grp_n && sel.lint_n && sel.sint_n && sel.rom_n && sel.ext_n;
  end
endmodule
`default_nettype wire

/* File: core/iopd_top.sv */
// i/o port decode, strobe and local acknowledge logic
// assumes processor holds address and command until ready
`timescale 1ns/100ps
`default_nettype none
module iopd_top (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [7:0] port_addr,               // full port address
  input  wire logic       io_read_cmd_n,           // i/o read command
  input  wire logic       io_write_cmd_n,          // i/o write command
  input  wire logic [7:0] cpu_data_in,             // processor data for latch load
  output logic            port_addr_bit0,          // command/data qualifier to chips
  output logic            port_addr_bit1_n,        // serial channel / counter select
  output logic            port_addr_bit2_n,        // group split, buffered
  output logic            counter_rd_n,            // counter chip read strobe
  output logic            counter_wr_n,            // counter chip write strobe
  output logic            serial_read_strobe_n,    // shared serial read
  output logic            serial_write_strobe_n,   // shared serial write
  output logic            serial0_sel_n,           // channel 0 chip select
  output logic            serial1_sel_n,           // channel 1 chip select
  output logic            first_intc_sel_n,        // local interrupt controller
  output logic            second_intc_sel_n,       // system interrupt controller
  output logic            parallel_sub_sel_n,      // parallel subsystem select
  output logic            io_ctrl_sel_n,           // i/o controller select
  output logic            ext_drv_en_n,            // external driver enable
  output logic            ext_drv_dir_in,          // external drivers toward cpu
  output logic            local_xcvr_en_n,         // local transceiver enable
  output logic            local_xcvr_dir_in,       // local transceiver toward cpu
  output logic            local_io_sel_n,          // common local select
  output logic            local_ready,             // ready to processor
  output logic [7:0]      rom_segment_enable_latch // rom enable latch value
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // decode is purely combinational; every output below is registered
  iopd_sel_if sel ();               // decoded selects
  iopd_port_decoder u_dec (
    .port_addr (port_addr),
    .sel       (sel)
  );

  logic rd_c;                        // read command active
  logic wr_c;                        // write command active
  logic cmd_c;                       // any command active
  logic ser_c;                       // serial half of group
  logic cnt_c;                       // counter half of group
  // commands gate strobes, enables and the timer; they never reach the address decode
  assign rd_c  = !io_read_cmd_n;
  assign wr_c  = !io_write_cmd_n;
  assign cmd_c = rd_c || wr_c;
  // bit two splits counter (f0-f3) from serial (f4-f7)
  assign ser_c = !sel.cnt_grp_n && port_addr[2];
  assign cnt_c = !sel.cnt_grp_n && !port_addr[2];

  // ----------------------------------------------------------------
  // acknowledge timer
  // ----------------------------------------------------------------
  iopd_pkg::iopd_ack_state_t ack_q;   // timer state
  logic [7:0]               cnt_q;   // cycles since start
  // cnt_q counts the edges at which the command was seen; the compare
  // sits one below the target so ready lands on the target edge
  // the timer restarts only once the command drops, so a held
  // command cannot produce a second ready pulse in one cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ack_q <= iopd_pkg::ACK_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      case (ack_q)
        iopd_pkg::ACK_IDLE:
        begin
          cnt_q <= iopd_pkg::ACK_ONE;
          // start only on a local cycle with a command
          if (cmd_c && !sel.local_n)
            ack_q <= iopd_pkg::ACK_RUN;
        end
        iopd_pkg::ACK_RUN:
        begin
          if (!cmd_c)
            ack_q <= iopd_pkg::ACK_IDLE;                 // aborted cycle
          else if (cnt_q >= iopd_pkg::ACK_CYCLES - iopd_pkg::ACK_ONE)
            ack_q <= iopd_pkg::ACK_DONE;
          else
            cnt_q <= cnt_q + iopd_pkg::ACK_ONE;
        end
        iopd_pkg::ACK_DONE:
        begin
          // relies on master holding command until ready
          if (!cmd_c)
            ack_q <= iopd_pkg::ACK_IDLE;
        end
        default:
          ack_q <= iopd_pkg::ACK_IDLE;
      endcase
    end
  end

  // ready registered: high while done and command held
  always_ff @(posedge core_clk)
  begin
    if (rst)
      local_ready <= 1'b0;
    else
      local_ready <= (ack_q == iopd_pkg::ACK_RUN) && cmd_c
                     && (cnt_q >= iopd_pkg::ACK_CYCLES - iopd_pkg::ACK_ONE)
                     || (ack_q == iopd_pkg::ACK_DONE) && cmd_c;
  end

  // ----------------------------------------------------------------
  // selects, address and data path, registered
  // ----------------------------------------------------------------
  // address-only selects, one cycle behind the address
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      port_addr_bit0     <= 1'b0;
      port_addr_bit1_n   <= 1'b1;
      port_addr_bit2_n   <= 1'b1;
      serial0_sel_n      <= 1'b1;
      serial1_sel_n      <= 1'b1;
      first_intc_sel_n   <= 1'b1;
      second_intc_sel_n  <= 1'b1;
      parallel_sub_sel_n <= 1'b1;
      io_ctrl_sel_n      <= 1'b1;
      local_io_sel_n     <= 1'b1;
    end
    else
    begin
      port_addr_bit0     <= port_addr[0];
      port_addr_bit1_n   <= !port_addr[1];
      port_addr_bit2_n   <= !port_addr[2];
      serial0_sel_n      <= !(ser_c && !port_addr[1]);
      serial1_sel_n      <= !(ser_c && port_addr[1]);
      first_intc_sel_n   <= sel.lint_n;
      second_intc_sel_n  <= sel.sint_n;
      parallel_sub_sel_n <= sel.par_n;
      io_ctrl_sel_n      <= sel.ioc_n;
      local_io_sel_n     <= sel.local_n;
    end
  end

  // strobes: commands only give direction to the selected chip
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      counter_rd_n          <= 1'b1;
      counter_wr_n          <= 1'b1;
      serial_read_strobe_n  <= 1'b1;
      serial_write_strobe_n <= 1'b1;
    end
    else
    begin
      counter_rd_n          <= !(cnt_c && rd_c);
      counter_wr_n          <= !(cnt_c && wr_c);
      serial_read_strobe_n  <= !(ser_c && rd_c);
      serial_write_strobe_n <= !(ser_c && wr_c);
    end
  end

  // data path enables open only during a command
  // external direction follows the read command alone, whatever the port
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      local_xcvr_en_n   <= 1'b1;
      local_xcvr_dir_in <= 1'b0;
      ext_drv_en_n      <= 1'b1;
      ext_drv_dir_in    <= 1'b0;
    end
    else
    begin
      local_xcvr_en_n   <= !(cmd_c && !sel.int_en_n);
      local_xcvr_dir_in <= rd_c && !sel.int_en_n;
      ext_drv_en_n      <= !(cmd_c && !sel.ext_n);
      ext_drv_dir_in    <= rd_c;
    end
  end

  // ----------------------------------------------------------------
  // rom enable latch, write only
  // ----------------------------------------------------------------
  // a reset while a write is still held reloads the latch one edge later
  // loaded on the first cycle of a write; a held write reloads
  // the same byte, which is harmless
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rom_segment_enable_latch <= iopd_pkg::ROM_LATCH_RST;
    else if (wr_c && !sel.rom_n)
      rom_segment_enable_latch <= cpu_data_in;
  end
endmodule
`default_nettype wire

/* File: dv/iopd_monitor.sv */
// checker for the port decode and acknowledge block, top ports only
// assumes synchronous active high reset on the single core clock
`timescale 1ns/100ps
`default_nettype none
module iopd_monitor (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [7:0] port_addr,
  input wire logic       io_read_cmd_n,
  input wire logic       io_write_cmd_n,
  input wire logic       counter_rd_n,
  input wire logic       counter_wr_n,
  input wire logic       serial_read_strobe_n,
  input wire logic       serial0_sel_n,
  input wire logic       serial1_sel_n,
  input wire logic       second_intc_sel_n,
  input wire logic       io_ctrl_sel_n,
  input wire logic       ext_drv_en_n,
  input wire logic       ext_drv_dir_in,
  input wire logic       local_xcvr_en_n,
  input wire logic       local_io_sel_n,
  input wire logic       local_ready,
  input wire logic [7:0] rom_segment_enable_latch
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic       cmd;   // any command active
  logic       loc;   // address in the local set
  logic [7:0] cyc_q; // samples of the current local command, saturating
  assign cmd = !io_read_cmd_n || !io_write_cmd_n;
  assign loc = (port_addr >= 8'h00_F0 && port_addr != 8'h00_FE) || (port_addr >= 8'h00_C0 && port_addr <= 8'h00_C5);
  // counter restarts whenever the command drops, so an abort never carries over
  always_ff @(posedge core_clk)
  begin
    if (rst || !(cmd && loc))
      cyc_q <= 8'h00_00;
    else if (cyc_q != 8'h00_FF)
      cyc_q <= cyc_q + 8'h00_01;
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ready_too_early: assert property ($rose(local_ready) |-> cyc_q >= 8'h00_9F && cyc_q <= 8'h00_A1)
    else $error("ready rose outside the acknowledge time");
  a_ready_too_late: assert property (cyc_q == 8'h00_A1 |-> local_ready)
    else $error("ready missing after acknowledge time");
  a_ready_drop: assert property (!cmd |=> !local_ready)
    else $error("ready held after command ended");
  a_counter_strobe: assert property (!counter_rd_n || !counter_wr_n |-> $past(port_addr[7:2]) == 6'h3C)
    else $error("counter strobe outside counter ports");
  a_serial_pair: assert property (!serial_read_strobe_n |->
    serial0_sel_n != serial1_sel_n && !local_io_sel_n)
    else $error("serial strobe without exactly one channel");
  a_reserved_quiet: assert property (port_addr == 8'h00_FE |=>
    local_io_sel_n && local_xcvr_en_n && ext_drv_en_n)
    else $error("reserved port produced a select");
  a_sys_intc_direct: assert property (!second_intc_sel_n |-> local_xcvr_en_n)
    else $error("transceiver enabled for system controller");
  a_ioc_ext_enable: assert property (cmd && port_addr[7:2] == 6'h30 |=> !io_ctrl_sel_n && !ext_drv_en_n)
    else $error("controller port missed select or enable");
  a_ext_dir_read: assert property (!io_read_cmd_n |=> ext_drv_dir_in)
    else $error("external direction not inward on read");
  a_latch_write: assert property (!$stable(rom_segment_enable_latch) |->
    $past(port_addr) == 8'h00_FF && !$past(io_write_cmd_n))
    else $error("latch changed without write to its port");
endmodule
bind iopd_top iopd_monitor mon (
  .core_clk(core_clk), .rst(rst), .port_addr(port_addr), .io_read_cmd_n(io_read_cmd_n),
  .io_write_cmd_n(io_write_cmd_n), .counter_rd_n(counter_rd_n), .counter_wr_n(counter_wr_n),
  .serial_read_strobe_n(serial_read_strobe_n), .serial0_sel_n(serial0_sel_n), .serial1_sel_n(serial1_sel_n),
  .second_intc_sel_n(second_intc_sel_n), .io_ctrl_sel_n(io_ctrl_sel_n), .ext_drv_en_n(ext_drv_en_n),
  .ext_drv_dir_in(ext_drv_dir_in), .local_xcvr_en_n(local_xcvr_en_n), .local_io_sel_n(local_io_sel_n),
  .local_ready(local_ready), .rom_segment_enable_latch(rom_segment_enable_latch));
`default_nettype wire

/* File: dv/iopd_master_model.sv */
// master processor model issuing single-byte port cycles
// assumes the block answers with a level ready signal
`timescale 1ns/100ps
`default_nettype none
module iopd_master_model (
  output logic [7:0] port_addr,
  output logic       io_read_cmd_n,
  output logic       io_write_cmd_n,
  output logic [7:0] cpu_data_in,
  input  wire logic  core_clk,
  input  wire logic  local_ready
);
  int lat; // cycles from sampled command to seen ready
  initial {port_addr, io_read_cmd_n, io_write_cmd_n, cpu_data_in} = {8'h00_00, 2'h3, 8'h00_5A};
  // start a cycle just after an edge; returns once the block has sampled it
  task automatic go(input logic [7:0] a, input logic wr, input logic [7:0] d);
    @(posedge core_clk);
    port_addr      <= a;
    io_read_cmd_n  <= wr;
    io_write_cmd_n <= !wr;
    cpu_data_in    <= wr ? d : ~cpu_data_in; // data lines not driven on reads show junk
    @(posedge core_clk);
    #1;
  endtask
  // hold everything until ready or the hold limit, then release; lines then show inverted values
  task automatic done(input int hold);
    lat = 1;
    while (local_ready !== 1'b1 && lat < hold)
    begin
      @(posedge core_clk);
      #1;
      lat++;
    end
    @(posedge core_clk);
    {io_read_cmd_n, io_write_cmd_n} <= 2'h3;
    port_addr   <= ~port_addr;
    cpu_data_in <= ~cpu_data_in;
    @(posedge core_clk);
    #1;
  endtask
endmodule
`default_nettype wire

/* File: dv/iopd_tb.sv */
// self-checking bench for the port decode and acknowledge block
// assumes the master model and the bound checker are compiled alongside
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        core_clk = 1'b0; // 100 MHz clock
  logic        rst = 1'b1;      // synchronous reset
  wire  [7:0]  addr;            // master address
  wire         rd_n;            // read command
  wire         wr_n;            // write command
  wire  [7:0]  wdat;            // master data
  wire  [17:0] vec;             // decode outputs side by side
  wire  [7:0]  latch;           // latch output
  wire         rdy;             // ready to master
  logic [7:0]  exp_latch = 8'h00_00;
  logic [17:0] e;               // expected decode outputs
  logic [7:0]  a;               // address under test
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;
  always #5 core_clk = ~core_clk;
  iopd_top dut (.core_clk(core_clk), .rst(rst), .port_addr(addr), .io_read_cmd_n(rd_n), .io_write_cmd_n(wr_n),
    .cpu_data_in(wdat), .port_addr_bit0(vec[17]), .port_addr_bit1_n(vec[16]), .port_addr_bit2_n(vec[15]),
    .counter_rd_n(vec[14]), .counter_wr_n(vec[13]), .serial_read_strobe_n(vec[12]), .serial_write_strobe_n(vec[11]),
    .serial0_sel_n(vec[10]), .serial1_sel_n(vec[9]), .first_intc_sel_n(vec[8]), .second_intc_sel_n(vec[7]),
    .parallel_sub_sel_n(vec[6]), .io_ctrl_sel_n(vec[5]), .ext_drv_en_n(vec[4]), .ext_drv_dir_in(vec[3]),
    .local_xcvr_en_n(vec[2]), .local_xcvr_dir_in(vec[1]), .local_io_sel_n(vec[0]), .local_ready(rdy),
    .rom_segment_enable_latch(latch));
  iopd_master_model mst (.core_clk(core_clk), .port_addr(addr), .io_read_cmd_n(rd_n), .io_write_cmd_n(wr_n),
    .cpu_data_in(wdat), .local_ready(rdy));
  // expected outputs one cycle after a held address and command
  function automatic logic [17:0] exp_vec(input logic [7:0] p, input logic rd, input logic wr);
    logic cnt, ser, ext, xi, loc;
    cnt = p[7:2] == 6'h3C;
    ser = p[7:2] == 6'h3D;
    ext = p[7:1] == 7'h7C || (p >= 8'h00_C0 && p <= 8'h00_C5);
    xi  = p[7:3] == 5'h1E || p[7:1] == 7'h7D; // system controller bypasses the transceiver
    loc = (p >= 8'h00_F0 && p != 8'h00_FE) || (p >= 8'h00_C0 && p <= 8'h00_C5);
    return {p[0], ~p[1], ~p[2], ~(cnt & rd), ~(cnt & wr), ~(ser & rd), ~(ser & wr), p[7:1] != 7'h7A,
      p[7:1] != 7'h7B, p[7:1] != 7'h7D, p[7:1] != 7'h7E, p[7:1] != 7'h7C, p[7:2] != 6'h30,
      ~(ext & (rd | wr)), rd, ~(xi & (rd | wr)), rd & xi, ~loc};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, well above the roughly 8000 cycles the sequence needs
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    check(vec, 18'h1_FFF5);
    check(latch, exp_latch);
    // every decoded port, reserved ones and one foreign port, read then write
    for (int i = 0; i < 46; i++)
    begin
      a = (i % 23) < 16 ? 8'(8'h00_F0 + i % 23) : (i % 23) < 22 ? 8'(8'h00_B0 + i % 23) : 8'h00_00;
      e = exp_vec(a, i < 23, i >= 23);
      mst.go(a, i >= 23, a ^ 8'h00_3C);
      check(vec, e);
      if (i >= 23 && a == 8'h00_FF)
        exp_latch = a ^ 8'h00_3C;
      mst.done(200);
      check(mst.lat >= 159 && mst.lat <= 161, !e[0]);
      check(rdy, 1'b0);
      check(latch, exp_latch);
    end
    // abort before ready, then a fresh transfer must take the full time again
    mst.go(8'h00_F2, 1'b0, 8'h00_00);
    mst.done(50);
    mst.go(8'h00_F2, 1'b0, 8'h00_00);
    mst.done(200);
    check(mst.lat >= 159 && mst.lat <= 161, 1'b1);
    // reset in mid-transfer clears the latch
    mst.go(8'h00_FF, 1'b1, 8'h00_A5);
    check(latch, 8'h00_A5);
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    #1;
    check(latch, 8'h00_00);
    mst.done(5);
    end_of_test();
  end
endmodule
`default_nettype wire
